/* File: rtl/dmpg_pkg.sv */
// Constants and types for the dead-time mode and power-up gate block
package dmpg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned OPEN_FILT_NS  = 3000;
  localparam int unsigned SHORT_FILT_NS = 2000;
  localparam int unsigned POWERUP_NS    = 18000;
  localparam int unsigned MIN_GAP_NS    = 10;
  localparam int unsigned NS_PER_KOHM   = 10;

  // Least times round up, never below one cycle
  localparam int unsigned OPEN_FILT_CYC  = (OPEN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_FILT_CYC = (SHORT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_CYC    = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_GAP_RAW    = (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_GAP_CYC    = (MIN_GAP_RAW < 1) ? 1 : MIN_GAP_RAW;

  localparam logic [6:0]  OPEN_LIMIT  = 7'(OPEN_FILT_CYC);
  localparam logic [6:0]  SHORT_LIMIT = 7'(SHORT_FILT_CYC);
  localparam logic [8:0]  PWR_LIMIT   = 9'(POWERUP_CYC);
  localparam logic [6:0]  MIN_GAP     = 7'(MIN_GAP_CYC);
  localparam logic [8:0]  RES_MIN     = 9'h001;
  localparam logic [8:0]  RES_MAX     = 9'h12c;
  localparam logic [11:0] NS_PER_K12  = 12'(NS_PER_KOHM);
  localparam logic [11:0] PERIOD12    = 12'(CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    DMPG_MIN_GAP = 3'b001,
    DMPG_RES_GAP = 3'b010,
    DMPG_OVERLAP = 3'b100
  } dmpg_mode_t;

  typedef struct packed {
    dmpg_mode_t mode;
    dmpg_mode_t cand;
    logic [6:0] filt;
    logic [8:0] pwr;
    logic       ready;
    logic       out_a;
    logic       out_b;
    logic [6:0] off_a;
    logic [6:0] off_b;
  } dmpg_state_t;
endpackage

/* File: rtl/dmpg_gate.sv */
// Dead-time mode selection, dead-time insertion and power-up output gating
`timescale 1ns/1ns
`default_nettype none
module dmpg_gate (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Channel inputs from the controller
  input  wire logic       channel_a_input,
  input  wire logic       channel_b_input,
  // Select pin comparators and programmed resistance in kilohms
  input  wire logic       gap_pin_high,
  input  wire logic       gap_pin_low,
  input  wire logic [8:0] gap_set_resistor,
  // Output-side supply status
  input  wire logic       supply_por_ok,
  input  wire logic       supply_low_lockout_ok,
  // Gate outputs and status
  output logic            channel_a_gate_out,
  output logic            channel_b_gate_out,
  output logic [2:0]      gap_mode,
  output logic            output_ready
);
  dmpg_pkg::dmpg_state_t st_reg;
  dmpg_pkg::dmpg_state_t st_next;
  logic [6:0]            gap_cyc;
  dmpg_pkg::dmpg_mode_t  pin_mode;
  logic [6:0]            limit;

  function automatic dmpg_pkg::dmpg_mode_t decode_pin(input logic hi, input logic lo);
    if (hi)
      return dmpg_pkg::DMPG_OVERLAP;
    else if (lo)
      return dmpg_pkg::DMPG_MIN_GAP;
    else
      return dmpg_pkg::DMPG_RES_GAP;
  endfunction

  function automatic logic [6:0] res_cycles(input logic [8:0] r);
    logic [8:0]  rc;
    logic [11:0] ns;
    rc = (r < dmpg_pkg::RES_MIN) ? dmpg_pkg::RES_MIN :
         (r > dmpg_pkg::RES_MAX) ? dmpg_pkg::RES_MAX : r;
    ns = {3'h0, rc} * dmpg_pkg::NS_PER_K12;
    return 7'((ns + dmpg_pkg::PERIOD12 - 12'h001) / dmpg_pkg::PERIOD12);
  endfunction

  always_comb
  begin
    st_next  = st_reg;
    pin_mode = decode_pin(gap_pin_high, gap_pin_low);
    // Open filter is the longer one; short and resistor share the 2 us window
    limit    = (st_reg.cand == dmpg_pkg::DMPG_OVERLAP) ? dmpg_pkg::OPEN_LIMIT
                                                       : dmpg_pkg::SHORT_LIMIT;
    unique case (st_reg.mode)
      dmpg_pkg::DMPG_MIN_GAP: gap_cyc = dmpg_pkg::MIN_GAP;
      dmpg_pkg::DMPG_RES_GAP: gap_cyc = res_cycles(gap_set_resistor);
      dmpg_pkg::DMPG_OVERLAP: gap_cyc = 7'h00;
      default:                gap_cyc = dmpg_pkg::MIN_GAP;
    endcase

    // Mode filter: a new level must persist for the whole window
    if (pin_mode != st_reg.cand)
    begin
      st_next.cand = pin_mode;
      st_next.filt = 7'h01;
    end
    else if (st_reg.filt < limit)
      st_next.filt = st_reg.filt + 7'h01;
    if (pin_mode == st_reg.cand && st_reg.filt >= limit)
      st_next.mode = st_reg.cand;

    // Power-up gate: restarts whenever the supply drops below reset
    if (!supply_por_ok)
      st_next.pwr = 9'h000;
    else if (st_reg.pwr < dmpg_pkg::PWR_LIMIT)
      st_next.pwr = st_reg.pwr + 9'h001;
    st_next.ready = supply_por_ok && supply_low_lockout_ok
                    && st_reg.pwr >= dmpg_pkg::PWR_LIMIT;

    // Off-time counters stop one short of all ones so off + 1 never wraps
    st_next.off_a = st_reg.out_a ? 7'h00 : (st_reg.off_a == 7'h7e ? 7'h7e : st_reg.off_a + 7'h01);
    st_next.off_b = st_reg.out_b ? 7'h00 : (st_reg.off_b == 7'h7e ? 7'h7e : st_reg.off_b + 7'h01);

    if (!st_reg.ready)
    begin
      st_next.out_a = 1'b0;
      st_next.out_b = 1'b0;
    end
    else if (st_reg.mode == dmpg_pkg::DMPG_OVERLAP)
    begin
      st_next.out_a = channel_a_input;
      st_next.out_b = channel_b_input;
    end
    else
    begin
      // Both inputs high is shoot-through: both stay off
      st_next.out_a = channel_a_input && !channel_b_input && !st_reg.out_b
                      && (st_reg.off_b + 7'h01 >= gap_cyc);
      st_next.out_b = channel_b_input && !channel_a_input && !st_reg.out_a
                      && (st_reg.off_a + 7'h01 >= gap_cyc);
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg       <= '0;
      st_reg.mode  <= dmpg_pkg::DMPG_MIN_GAP;
      st_reg.cand  <= dmpg_pkg::DMPG_MIN_GAP;
      st_reg.off_a <= 7'h7e;
      st_reg.off_b <= 7'h7e;
    end
    else
      st_reg <= st_next;
  end

  assign channel_a_gate_out = st_reg.out_a;
  assign channel_b_gate_out = st_reg.out_b;
  assign gap_mode           = st_reg.mode;
  assign output_ready       = st_reg.ready;

  // Assertion helper: consecutive samples of the high comparator
  logic [7:0] run_hi;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      run_hi <= 8'h00;
    else if (!gap_pin_high)
      run_hi <= 8'h00;
    else if (run_hi != 8'hff)
      run_hi <= run_hi + 8'h01;
  end

  sequence s_gate_open;
    st_reg.ready && st_reg.mode != dmpg_pkg::DMPG_OVERLAP;
  endsequence

  property p_no_overlap;
    @(posedge core_clk) disable iff (!nrst)
    s_gate_open |=> !(st_reg.out_a && st_reg.out_b);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("Outputs overlap");

  property p_held_off;
    @(posedge core_clk) disable iff (!nrst)
    !st_reg.ready |=> !channel_a_gate_out && !channel_b_gate_out;
  endproperty
  a_held_off: assert property (p_held_off) else $error("Output before ready");

  property p_overlap_follow;
    @(posedge core_clk) disable iff (!nrst)
    (st_reg.ready && st_reg.mode == dmpg_pkg::DMPG_OVERLAP)
      |=> channel_a_gate_out == $past(channel_a_input)
          && channel_b_gate_out == $past(channel_b_input);
  endproperty
  a_overlap_follow: assert property (p_overlap_follow) else $error("Overlap not following");

  property p_open_enter;
    @(posedge core_clk) disable iff (!nrst)
    $rose(st_reg.mode == dmpg_pkg::DMPG_OVERLAP) |-> $past(run_hi) >= 8'(dmpg_pkg::OPEN_LIMIT);
  endproperty
  a_open_enter: assert property (p_open_enter) else $error("Overlap entered early");

  property p_open_hold;
    @(posedge core_clk) disable iff (!nrst)
    run_hi > 8'(dmpg_pkg::OPEN_LIMIT) |-> st_reg.mode == dmpg_pkg::DMPG_OVERLAP;
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("Overlap not entered");

  property p_pwr_delay;
    @(posedge core_clk) disable iff (!nrst)
    $rose(st_reg.ready) |-> $past(st_reg.pwr) == dmpg_pkg::PWR_LIMIT;
  endproperty
  a_pwr_delay: assert property (p_pwr_delay) else $error("Ready before delay");

  property p_lockout_enable;
    @(posedge core_clk) disable iff (!nrst)
    (supply_por_ok && supply_low_lockout_ok && st_reg.pwr == dmpg_pkg::PWR_LIMIT)
      |=> output_ready;
  endproperty
  a_lockout_enable: assert property (p_lockout_enable) else $error("Ready missing");

  property p_gap_kept;
    @(posedge core_clk) disable iff (!nrst)
    ($rose(st_reg.out_a) && $past(st_reg.mode) != dmpg_pkg::DMPG_OVERLAP)
      |-> $past(st_reg.off_b) + 7'h01 >= $past(gap_cyc);
  endproperty
  a_gap_kept: assert property (p_gap_kept) else $error("Dead time too short");

  property p_long_gap_pass;
    @(posedge core_clk) disable iff (!nrst)
    (s_gate_open and (channel_a_input && !channel_b_input && !st_reg.out_b
      && st_reg.off_b + 7'h01 >= gap_cyc)) |=> channel_a_gate_out;
  endproperty
  a_long_gap_pass: assert property (p_long_gap_pass) else $error("Long gap delayed");
endmodule // dmpg_gate
`default_nettype wire

/* File: dv/dmpg_pwm_model.sv */
// Behavioural PWM controller driving the channel inputs
`timescale 1ns/1ns
`default_nettype none
module dmpg_pwm_model (
  // Clock, reset, supply and pattern controls
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       por_ok,
  input  wire logic       early,
  input  wire logic       overlap,
  input  wire logic [3:0] gap,
  // Channel inputs of the block
  output logic            in_a,
  output logic            in_b
);
  localparam int WAIT = 30000 / dmpg_pkg::CLK_PERIOD_NS;
  int ph  = 0;
  int cnt = 0;
  int g;
  always_ff @(posedge core_clk)
    ph <= (ph >= 2 * (8 + g) - 1) ? 0 : ph + 1;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      cnt <= 0;
    else
      cnt <= !por_ok ? 0 : (cnt < WAIT) ? cnt + 1 : cnt;
  // Early switching is a deliberate breach, only to probe the gating
  always_comb
  begin
    g    = int'(gap);
    in_a = (early || cnt >= WAIT) && ph < 8;
    in_b = (early || cnt >= WAIT) && (overlap ? ph < 8 : ph >= 8 + g && ph < 16 + g);
  end
endmodule // dmpg_pwm_model
`default_nettype wire

/* File: dv/dmpg_gate_bench.sv */
// Self-checking bench for the dead-time mode and power-up gate
`timescale 1ns/1ns
`default_nettype none
module dmpg_gate_bench;
  localparam int OPN = dmpg_pkg::OPEN_FILT_CYC;
  localparam int SHT = dmpg_pkg::SHORT_FILT_CYC;
  logic       core_clk = 1'b0, nrst = 1'b0, hi = 1'b0, lo = 1'b1, por = 1'b0;
  logic       lock = 1'b0, early = 1'b1, ovl = 1'b0, in_a, in_b, out_a, out_b, ready;
  logic [3:0] gap = 4'h0;
  logic [8:0] res = 9'h00c;
  logic [2:0] mode;
  int         err_total = 0, checked = 0;
  always #20 core_clk = ~core_clk;
  dmpg_gate dut (.core_clk(core_clk), .nrst(nrst), .channel_a_input(in_a),
    .channel_b_input(in_b), .gap_pin_high(hi), .gap_pin_low(lo), .gap_set_resistor(res),
    .supply_por_ok(por), .supply_low_lockout_ok(lock), .channel_a_gate_out(out_a),
    .channel_b_gate_out(out_b), .gap_mode(mode), .output_ready(ready));
  dmpg_pwm_model ctrl (.core_clk(core_clk), .nrst(nrst), .por_ok(por), .early(early),
    .overlap(ovl), .gap(gap), .in_a(in_a), .in_b(in_b));
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic int gcyc(input int kohm);
    int ns;
    ns = (kohm < 1 ? 1 : kohm > 300 ? 300 : kohm) * dmpg_pkg::NS_PER_KOHM;
    return (ns + dmpg_pkg::CLK_PERIOD_NS - 1) / dmpg_pkg::CLK_PERIOD_NS;
  endfunction
  task automatic wait_ready(input int lim, output int n);
    n = 0;
    while (ready !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (ready !== 1'b1)
        check("gates held off", {out_a, out_b}, 0);
      if (n > lim)
      begin
        err_total++;
        end_of_test();
      end
    end
  endtask
  // Pass case keeps the pins; refused case restores them after n samples
  task automatic set_pin(input logic h, l, input int n, input logic keep, input logic [2:0] exp);
    logic [2:0] was;
    logic [1:0] pins;
    was  = mode;
    pins = {hi, lo};
    @(posedge core_clk);
    {hi, lo} <= {h, l};
    repeat (n) @(posedge core_clk);
    if (!keep)
      {hi, lo} <= pins;
    @(negedge core_clk);
    check("mode before", mode, was);
    @(negedge core_clk);
    check("mode", mode, exp);
    repeat (4) @(negedge core_clk);
    check("mode held", mode, exp);
  endtask
  // Measures every both-off run between gate pulses
  task automatic chk_gates(input logic o, input logic [3:0] g, input int run_exp, input logic both_exp);
    int   run;
    logic on;
    logic both;
    run  = 0;
    on   = 1'b0;
    both = 1'b0;
    @(posedge core_clk);
    ovl <= o;
    gap <= g;
    repeat (40) @(posedge core_clk);
    repeat (100)
    begin
      @(negedge core_clk);
      both = both | (out_a & out_b);
      if (!(out_a | out_b))
        run++;
      else
      begin
        if (on && run > 0)
          check("dead run", run, run_exp);
        on  = 1'b1;
        run = 0;
      end
    end
    check("both on", both, both_exp);
  endtask
  task automatic t_power;
    int n;
    @(posedge core_clk);
    por  <= 1'b1;
    lock <= 1'b1;
    wait_ready(600, n);
    check("fast rise", n, dmpg_pkg::PWR_LIMIT + 1);
    @(posedge core_clk);
    lock <= 1'b0;
    repeat (602) @(posedge core_clk);
    #1;
    check("lockout low", ready, 0);
    @(posedge core_clk);
    lock <= 1'b1;
    wait_ready(2, n);
    check("slow rise", n, 1);
    @(posedge core_clk);
    early <= 1'b0;
    $display("power-up test done");
  endtask
  task automatic t_mode;
    chk_gates(1'b0, 4'h0, dmpg_pkg::MIN_GAP_CYC, 1'b0);
    chk_gates(1'b0, 4'h4, 4, 1'b0);
    chk_gates(1'b1, 4'h0, 0, 1'b0);
    set_pin(1'b1, 1'b0, OPN - 1, 1'b0, dmpg_pkg::DMPG_MIN_GAP);
    set_pin(1'b1, 1'b0, OPN, 1'b1, dmpg_pkg::DMPG_OVERLAP);
    chk_gates(1'b1, 4'h0, 8, 1'b1);
    set_pin(1'b0, 1'b0, SHT, 1'b1, dmpg_pkg::DMPG_RES_GAP);
    chk_gates(1'b0, 4'h0, gcyc(12), 1'b0);
    @(posedge core_clk);
    res <= 9'h000;
    chk_gates(1'b0, 4'h0, gcyc(0), 1'b0);
    set_pin(1'b0, 1'b1, SHT, 1'b1, dmpg_pkg::DMPG_MIN_GAP);
    $display("mode test done");
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check("reset mode", mode, dmpg_pkg::DMPG_MIN_GAP);
    check("reset gates", {ready, out_a, out_b}, 0);
    $display("reset test done");
    t_power();
    t_mode();
    end_of_test();
  end
endmodule // dmpg_gate_bench
`default_nettype wire
